// ---- inc/mcd_pkg.sv ----
// package for the monitor command decoder: pages, addresses, command codes,
// request and answer structs, measurement sequencing constants.
// assumes a single 250 MHz clock domain and a request port fed by comms logic.
package mcd_pkg;
    // ==================== pages and addresses ====================
    localparam logic [2:0] PAGE_RESULT = 3'h1; // measurement results
    localparam logic [2:0] PAGE_CONFIG = 3'h2; // configuration page
    localparam logic [2:0] PAGE_CMD = 3'h3; // device commands
    localparam logic [2:0] PAGE_NV = 3'h4; // nonvolatile factory signature page
    localparam logic [2:0] PAGE_NVSH = 3'h5; // computed signature page
    localparam logic [5:0] ADDR_PACK = 6'h00;
    localparam logic [5:0] ADDR_CELL_LAST = 6'h0C;
    localparam logic [5:0] ADDR_NV_SIG = 6'h3F;
    localparam logic [5:0] ADDR_NV_SHADOW = 6'h00;
    localparam logic [5:0] ADDR_CFG_FIRST = 6'h10; // checksummed config range
    localparam logic [5:0] ADDR_CFG_LAST = 6'h1D;
    localparam logic [5:0] ADDR_BAL_FIRST = 6'h20; // balance value registers
    localparam logic [5:0] ADDR_BAL_LAST = 6'h37;
    localparam logic [3:0] ADDR_ALL_STACK = 4'hF; // broadcast stack address
    // ==================== command codes ====================
    localparam logic [5:0] CMD_SCAN_VOLT = 6'h01;
    localparam logic [5:0] CMD_SCAN_TEMP = 6'h02;
    localparam logic [5:0] CMD_SCAN_MIXED = 6'h03;
    localparam logic [5:0] CMD_SCAN_WIRES = 6'h04;
    localparam logic [5:0] CMD_SCAN_ALL = 6'h05;
    localparam logic [5:0] CMD_SCAN_CONT = 6'h06;
    localparam logic [5:0] CMD_SCAN_INH = 6'h07;
    localparam logic [5:0] CMD_MEASURE = 6'h08;
    localparam logic [5:0] CMD_IDENTIFY = 6'h09;
    localparam logic [5:0] CMD_SLEEP = 6'h0A;
    localparam logic [5:0] RSP_NAK = 6'h0B;
    localparam logic [5:0] CMD_ACK = 6'h0C;
    localparam logic [5:0] RSP_COMMS_FAIL = 6'h0E;
    localparam logic [5:0] CMD_WAKE = 6'h0F;
    localparam logic [5:0] CMD_BAL_EN = 6'h10;
    localparam logic [5:0] CMD_BAL_INH = 6'h11;
    localparam logic [5:0] CMD_RESET = 6'h12;
    localparam logic [5:0] CMD_CSUM_CALC = 6'h13;
    localparam logic [5:0] CMD_CSUM_CHECK = 6'h14;
    // ==================== widths and counts ====================
    localparam int DATA_W = 14;
    localparam int CELLS = 12;
    localparam int TEMPS = 7; // 4 external, internal, reference, spare slot
    localparam logic [DATA_W-1:0] ZERO_DATA = 14'h0000;
    localparam logic [3:0] SLOT_EXTERNAL_INPUT_ONE = 4'h1; // temp slot of external input one
    localparam logic [3:0] SLOT_INT = 4'h0; // internal temperature slot
    localparam logic [3:0] SLOT_REF = 4'h5; // secondary reference slot
    localparam logic [3:0] MIX_EXT_AT = 4'h6; // voltage scan step where ext sample is taken, before cell 6
    localparam logic [3:0] WAKE_DIV = 4'hF; // wake clock half period is this plus one, in clk cycles
    localparam logic [4:0] WAKE_EDGES = 5'h10; // wake clock edges sent
    // ==================== request and answer carriers ====================
    typedef struct packed {
        logic write; // 1 = write access
        logic [3:0] stack; // target stack address
        logic [2:0] page;
        logic [5:0] addr;
        logic [DATA_W-1:0] wdata;
    } mcd_req_t;
    typedef struct packed {
        logic [5:0] code; // response code, 0 for plain data
        logic [DATA_W-1:0] rdata;
    } mcd_rsp_t;
    typedef struct packed {
        logic [3:0] kind; // 0 cell, 1 pack, 2..8 temp slot
        logic [3:0] index; // cell number minus one
    } mcd_sel_t;
endpackage

// ---- rtl/mcd_decoder.sv ----
// monitor command decoder: runs commands, holds results, answers requests.
// assumes one-cycle request pulses and a converter answering each start.
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder
    import mcd_pkg::*;
#(
    parameter logic [DATA_W-1:0] FACTORY_SIG = 14'h1234, // arbitrary value
    parameter logic [3:0] OWN_ADDR_INIT = 4'h0
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire mcd_req_t req_i,
    input wire mcd_sel_t measure_sel_i,
    input wire logic fwd_nak_i, // downstream device failed to acknowledge
    input wire logic [3:0] stack_pos_i, // position found by identify
    input wire logic [3:0] stack_size_i,
    input wire logic link_clk_i, // daisy link clock from neighbour
    input wire logic adc_done_i, // conversion complete, same domain
    input wire logic [DATA_W-1:0] adc_data_i,
    input wire logic [DATA_W-1:0] nv_word_i, // word from nonvolatile reload
    input wire logic nv_word_valid_i,
    input wire logic cfg_wr_i, // config write port for checksummed page
    input wire logic [5:0] cfg_addr_i,
    input wire logic [DATA_W-1:0] cfg_wdata_i,
    output logic rsp_valid_o,
    output mcd_rsp_t rsp_o,
    output logic adc_start_o,
    output mcd_sel_t adc_sel_o,
    output logic wire_test_o, // conversion is an open-wire test
    output logic scan_cont_o,
    output logic balance_enable_flag_o,
    output logic register_checksum_fault_o,
    output logic sleep_o,
    output logic wake_clk_o,
    output logic [3:0] own_addr_o,
    output logic [3:0] stack_size_o,
    output logic nv_reload_o // pulse: reload nonvolatile data
);
    // ==================== state ====================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_VOLT = 3'b001,
        ST_TEMP = 3'b011,
        ST_WIRE = 3'b010,
        ST_ONE = 3'b110
    } mcd_state_t;
    mcd_state_t state;
    logic all_mode; // scan all chains volt -> temp -> wire
    logic mixed_mode; // mixed scan inserts ext one sample
    logic ext_done; // ext one already taken in this mixed scan
    logic [3:0] step; // step index inside a sequence
    logic busy; // conversion outstanding
    logic [DATA_W-1:0] cell_res [CELLS]; // cell results
    logic [DATA_W-1:0] temp_res [TEMPS]; // temperature slot results
    logic [DATA_W-1:0] pack_res;
    logic [CELLS-1:0] open_wire; // wire scan results
    logic [DATA_W-1:0] cfg_reg [16]; // checksummed config words
    logic [DATA_W-1:0] bal_reg [24]; // balance value words
    logic [DATA_W-1:0] csum_held; // checksum captured by calc command
    logic [DATA_W-1:0] nv_shadow_sig; // signature of last reload
    logic [DATA_W-1:0] cfg_sum; // live checksum of config words
    logic link_s1, link_s2, link_s3; // link clock synchroniser and edge store
    logic [3:0] wake_div;
    logic [4:0] wake_cnt;
    logic reset_cmd; // reset command pulse
    logic addressed; // request is for this device
    logic cmd_rd; // awake, addressed read in the command page
    // ==================== request decode ====================
    // broadcast 1111 is accepted by every device
    assign addressed = (req_i.stack == own_addr_o) || (req_i.stack == ADDR_ALL_STACK);
    assign cmd_rd = req_valid_i && addressed && !req_i.write && (req_i.page == PAGE_CMD) && !sleep_o;
    assign reset_cmd = cmd_rd && (req_i.addr == CMD_RESET);
    // live checksum: sum rotated by word, cheap and order sensitive
    always_comb
    begin
        cfg_sum = ZERO_DATA;
        for (int i = 0; i < 16; i++)
        begin
            cfg_sum = {cfg_sum[DATA_W-2:0], cfg_sum[DATA_W-1]} ^ cfg_reg[i];
        end
    end
    // ==================== link clock sampling ====================
    // the second and third stages feed the edge detector
    always_ff @(posedge clk_i)
    begin
        link_s1 <= link_clk_i;
        link_s2 <= link_s1;
        link_s3 <= link_s2;
    end
    // ==================== answers ====================
    // one answer per addressed request while awake, one cycle after it, unless fwd_nak_i in the same cycle replaces it
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_o <= '0;
        end
        else if (fwd_nak_i)
        begin
            rsp_valid_o <= 1'b1;
            rsp_o <= '{code: RSP_COMMS_FAIL, rdata: ZERO_DATA};
        end
        else if (req_valid_i && addressed && !sleep_o)
        begin
            rsp_valid_o <= 1'b1;
            rsp_o <= '0; // code 0 marks a data read
            if (req_i.page == PAGE_CMD)
            begin
                if (req_i.write)
                    rsp_o.code <= RSP_NAK;
                else if (req_i.addr < CMD_SCAN_VOLT || req_i.addr > CMD_CSUM_CHECK
                    || req_i.addr == RSP_NAK || req_i.addr == 6'h0D || req_i.addr == RSP_COMMS_FAIL)
                    rsp_o.code <= RSP_NAK;
                else
                    rsp_o.code <= CMD_ACK;
            end
            else if (req_i.page == PAGE_RESULT && !req_i.write && req_i.addr <= ADDR_CELL_LAST)
                rsp_o.rdata <= (req_i.addr == ADDR_PACK) ? pack_res : cell_res[req_i.addr[3:0] - 4'h1];
            else if (req_i.page == PAGE_NV && !req_i.write && req_i.addr == ADDR_NV_SIG)
                rsp_o.rdata <= FACTORY_SIG;
            else if (req_i.page == PAGE_NVSH && !req_i.write && req_i.addr == ADDR_NV_SHADOW)
                rsp_o.rdata <= nv_shadow_sig;
            else
                rsp_o.code <= RSP_NAK;
        end
        else
            rsp_valid_o <= 1'b0;
    end
    // ==================== mode flags ====================
    // mode flags; reset command clears all
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || reset_cmd)
        begin
            scan_cont_o <= 1'b0;
            balance_enable_flag_o <= 1'b0;
            sleep_o <= 1'b0;
        end
        else if (sleep_o)
            sleep_o <= !(link_s2 ^ link_s3); // any link edge wakes
        else if (cmd_rd)
        begin
            unique case (req_i.addr)
                CMD_SCAN_CONT: scan_cont_o <= 1'b1;
                CMD_SCAN_INH: scan_cont_o <= 1'b0;
                CMD_BAL_EN: balance_enable_flag_o <= 1'b1;
                CMD_BAL_INH: balance_enable_flag_o <= 1'b0;
                CMD_SLEEP: sleep_o <= 1'b1;
                default: ;
            endcase
        end
    end
    // ==================== identify and checksum ====================
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || reset_cmd)
        begin
            own_addr_o <= OWN_ADDR_INIT;
            stack_size_o <= 4'h0;
            csum_held <= ZERO_DATA;
            register_checksum_fault_o <= 1'b0;
        end
        else if (cmd_rd)
        begin
            if (req_i.addr == CMD_IDENTIFY)
            begin
                own_addr_o <= stack_pos_i;
                stack_size_o <= stack_size_i;
            end
            if (req_i.addr == CMD_CSUM_CALC)
                csum_held <= cfg_sum;
            if (req_i.addr == CMD_CSUM_CHECK && cfg_sum != csum_held)
                register_checksum_fault_o <= 1'b1;
        end
    end
    // ==================== config, balance and reload ====================
    // reset command restarts the nonvolatile reload and signature
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || reset_cmd)
        begin
            for (int i = 0; i < 16; i++)
                cfg_reg[i] <= ZERO_DATA;
            for (int i = 0; i < 24; i++)
                bal_reg[i] <= ZERO_DATA;
            nv_shadow_sig <= ZERO_DATA;
            nv_reload_o <= 1'b1;
        end
        else
        begin
            nv_reload_o <= 1'b0;
            if (nv_word_valid_i)
                nv_shadow_sig <= {nv_shadow_sig[DATA_W-2:0], nv_shadow_sig[DATA_W-1]} ^ nv_word_i;
            if (cfg_wr_i && cfg_addr_i >= ADDR_CFG_FIRST && cfg_addr_i <= ADDR_CFG_LAST)
                cfg_reg[cfg_addr_i[3:0]] <= cfg_wdata_i;
            if (cfg_wr_i && cfg_addr_i >= ADDR_BAL_FIRST && cfg_addr_i <= ADDR_BAL_LAST)
                bal_reg[5'(cfg_addr_i - ADDR_BAL_FIRST)] <= cfg_wdata_i;
        end
    end
    // ==================== wake clock ====================
    // low frequency clock toward the stack after a wake command
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wake_cnt <= 5'h00;
            wake_div <= 4'h0;
            wake_clk_o <= 1'b0;
        end
        else if (req_valid_i && !req_i.write && req_i.page == PAGE_CMD && req_i.addr == CMD_WAKE)
        begin
            wake_cnt <= WAKE_EDGES;
            wake_div <= WAKE_DIV;
        end
        else if (wake_cnt != 5'h00)
        begin
            if (wake_div == 4'h0)
            begin
                wake_div <= WAKE_DIV;
                wake_clk_o <= ~wake_clk_o;
                wake_cnt <= wake_cnt - 5'h01;
            end
            else
                wake_div <= wake_div - 4'h1;
        end
        else
            wake_clk_o <= 1'b0;
    end
    // ==================== scan sequencer ====================
    // one conversion at a time; result stored on adc_done_i
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || reset_cmd)
        begin
            state <= ST_IDLE; // scans stop
            all_mode <= 1'b0;
            mixed_mode <= 1'b0;
            ext_done <= 1'b0;
            step <= 4'h0;
            busy <= 1'b0;
            adc_start_o <= 1'b0;
            adc_sel_o <= '0;
            wire_test_o <= 1'b0;
            pack_res <= ZERO_DATA;
            open_wire <= '0;
            for (int i = 0; i < CELLS; i++)
                cell_res[i] <= ZERO_DATA;
            for (int i = 0; i < TEMPS; i++)
                temp_res[i] <= ZERO_DATA;
        end
        else
        begin
            adc_start_o <= 1'b0;
            unique case (state)
                ST_IDLE:
                begin
                    step <= 4'h0;
                    ext_done <= 1'b0;
                    if (cmd_rd)
                    begin
                        all_mode <= (req_i.addr == CMD_SCAN_ALL);
                        mixed_mode <= (req_i.addr == CMD_SCAN_MIXED);
                        if (req_i.addr == CMD_SCAN_VOLT || req_i.addr == CMD_SCAN_MIXED
                            || req_i.addr == CMD_SCAN_ALL)
                            state <= ST_VOLT;
                        else if (req_i.addr == CMD_SCAN_TEMP)
                            state <= ST_TEMP;
                        else if (req_i.addr == CMD_SCAN_WIRES)
                            state <= ST_WIRE;
                        else if (req_i.addr == CMD_MEASURE)
                            state <= ST_ONE;
                    end
                    else if (scan_cont_o)
                        state <= ST_VOLT; // repeat voltage scans
                end
                default:
                begin
                    if (!busy)
                    begin
                        busy <= 1'b1;
                        adc_start_o <= 1'b1;
                        wire_test_o <= (state == ST_WIRE);
                        if (state == ST_ONE)
                            adc_sel_o <= measure_sel_i;
                        else if (state == ST_TEMP)
                            adc_sel_o <= '{kind: 4'h2 + step, index: 4'h0};
                        else if (mixed_mode && step == MIX_EXT_AT && !ext_done)
                            adc_sel_o <= '{kind: 4'h2 + SLOT_EXTERNAL_INPUT_ONE, index: 4'h0};
                        else if (state == ST_VOLT && step == 4'h0)
                            adc_sel_o <= '{kind: 4'h1, index: 4'h0};
                        else
                            adc_sel_o <= '{kind: 4'h0, index: step - (state == ST_VOLT ? 4'h1 : 4'h0)};
                    end
                    else if (adc_done_i)
                    begin
                        busy <= 1'b0;
                        if (state == ST_ONE)
                        begin
                            if (adc_sel_o.kind == 4'h1)
                                pack_res <= adc_data_i;
                            else if (adc_sel_o.kind == 4'h0)
                                cell_res[adc_sel_o.index] <= adc_data_i;
                            else
                                temp_res[3'(adc_sel_o.kind - 4'h2)] <= adc_data_i;
                            state <= ST_IDLE;
                        end
                        else if (state == ST_TEMP)
                        begin
                            temp_res[3'(step)] <= adc_data_i;
                            step <= step + 4'h1;
                            if (step == SLOT_REF)
                            begin
                                step <= 4'h0;
                                state <= all_mode ? ST_WIRE : ST_IDLE;
                            end
                        end
                        else if (state == ST_WIRE)
                        begin
                            open_wire[step] <= adc_data_i != ZERO_DATA;
                            step <= step + 4'h1;
                            if (step == 4'(CELLS - 1))
                                state <= ST_IDLE;
                        end
                        else if (mixed_mode && step == MIX_EXT_AT && !ext_done)
                        begin
                            temp_res[SLOT_EXTERNAL_INPUT_ONE[2:0]] <= adc_data_i;
                            ext_done <= 1'b1;
                        end
                        else
                        begin
                            if (step == 4'h0)
                                pack_res <= adc_data_i;
                            else
                                cell_res[step - 4'h1] <= adc_data_i;
                            step <= step + 4'h1;
                            if (step == 4'(CELLS))
                            begin
                                step <= 4'h0;
                                state <= all_mode ? ST_TEMP : ST_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verification/mcd_adc_model.sv ----
// behavioural converter answering the decoder's conversion requests.
// assumes one outstanding start at a time; data line scrambles while idle.
`timescale 1ns/1ps
`default_nettype none
module mcd_adc_model
    import mcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic start_i,
    input wire mcd_sel_t sel_i,
    output var logic done_o,
    output var logic [DATA_W-1:0] data_o
);
    // ==================== conversion ====================
    logic [1:0] wait_q = 2'h0; // cycles left of a conversion
    mcd_sel_t sel_q; // selection being converted
    initial done_o = 1'b0;
    initial data_o = 14'h0000;
    // result carries its selection so each slot is told apart
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        data_o <= ~data_o; // no stale value between results
        if (wait_q != 2'h0)
        begin
            wait_q <= wait_q - 2'h1;
            if (wait_q == 2'h1)
            begin
                done_o <= 1'b1;
                data_o <= {6'h20, sel_q};
            end
        end
        else if (start_i)
        begin
            wait_q <= 2'h3;
            sel_q <= sel_i;
        end
    end
endmodule
`default_nettype wire

// ---- verification/mcd_decoder_assertions.sv ----
// checker for the command decoder: answers and flag effects.
// assumes the decoder top ports, one clock and a sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder_assertions
    import mcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire mcd_req_t req_i,
    input wire logic fwd_nak_i,
    input wire logic sleep_o,
    input wire logic rsp_valid_o,
    input wire mcd_rsp_t rsp_o,
    input wire logic scan_cont_o,
    input wire logic balance_enable_flag_o,
    input wire logic nv_reload_o,
    input wire logic [3:0] own_addr_o
);
    // ==================== taken requests ====================
    logic tk; // addressed, awake, not beaten by a forward failure
    logic cr; // taken read in the command page
    assign tk = req_valid_i && !sleep_o && !fwd_nak_i && (req_i.stack == own_addr_o || req_i.stack == ADDR_ALL_STACK);
    assign cr = tk && !req_i.write && req_i.page == PAGE_CMD;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==================== properties ====================
    a_answer_once: assert property (tk |=> rsp_valid_o)
        else $error("no answer");
    a_ack_code: assert property (cr && req_i.addr == CMD_ACK |=> rsp_o.code == CMD_ACK)
        else $error("ack not answered");
    a_ack_keeps: assert property (cr && req_i.addr == CMD_ACK |=> $stable(balance_enable_flag_o) && $stable(scan_cont_o))
        else $error("ack changed state");
    a_cmd_write_nak: assert property (tk && req_i.write && req_i.page == PAGE_CMD |=> rsp_o.code == RSP_NAK)
        else $error("write to command page not refused");
    a_unassigned_nak: assert property (cr && req_i.addr == 6'h0D |=> rsp_o.code == RSP_NAK)
        else $error("unassigned command not refused");
    a_comms_fail: assert property (fwd_nak_i |=> rsp_valid_o && rsp_o.code == RSP_COMMS_FAIL)
        else $error("forward failure not reported");
    a_bal_set: assert property (cr && req_i.addr == CMD_BAL_EN |-> ##[1:2] balance_enable_flag_o)
        else $error("balance enable not set");
    a_bal_clear: assert property (cr && req_i.addr == CMD_BAL_INH |-> ##[1:2] !balance_enable_flag_o)
        else $error("balance enable not cleared");
    a_scan_set: assert property (cr && req_i.addr == CMD_SCAN_CONT |-> ##[1:2] scan_cont_o)
        else $error("continuous scan not set");
    a_scan_stop: assert property (cr && req_i.addr == CMD_SCAN_INH |-> ##[1:2] !scan_cont_o)
        else $error("continuous scan not cleared");
    a_sleep_enter: assert property (cr && req_i.addr == CMD_SLEEP |-> ##[1:2] sleep_o)
        else $error("sleep not entered");
    a_reset_reload: assert property (cr && req_i.addr == CMD_RESET |-> ##[1:2] nv_reload_o && !balance_enable_flag_o)
        else $error("reset did not reload");
    c_sleep: cover property (cr && req_i.addr == CMD_SLEEP);
    c_fail: cover property (fwd_nak_i);
    c_bcast: cover property (cr && req_i.stack == ADDR_ALL_STACK);
endmodule
bind mcd_decoder mcd_decoder_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .fwd_nak_i(fwd_nak_i), .sleep_o(sleep_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .scan_cont_o(scan_cont_o), .balance_enable_flag_o(balance_enable_flag_o), .nv_reload_o(nv_reload_o),
    .own_addr_o(own_addr_o));
`default_nettype wire

// ---- verification/mcd_decoder_tb.sv ----
// self-checking bench for the monitor command decoder, host side by hand.
// assumes the converter model answers every start a few cycles later.
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder_tb
    import mcd_pkg::*;
;
    localparam logic [DATA_W-1:0] SIG = 14'h2A5C; // arbitrary factory signature
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    mcd_req_t req_i = '0;
    mcd_sel_t measure_sel_i = 8'h10;
    logic fwd_nak_i = 1'b0;
    logic link_clk_i = 1'b0; // stands still outside frames
    logic cfg_wr_i = 1'b0;
    logic [5:0] cfg_addr_i = 6'h00;
    logic [DATA_W-1:0] cfg_wdata_i = 14'h0000;
    logic adc_done_i, rsp_valid_o, adc_start_o, wire_test_o, scan_cont_o, bal_o, fault_o, sleep_o, wake_clk_o, nv_reload_o;
    logic [DATA_W-1:0] adc_data_i;
    mcd_rsp_t rsp_o, got;
    mcd_sel_t adc_sel_o;
    logic [3:0] own_addr_o, stack_size_o;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_done = 0;
    int cyc = 0;
    always #2 clk_i = ~clk_i;
    mcd_decoder #(.FACTORY_SIG(SIG)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .measure_sel_i(measure_sel_i), .fwd_nak_i(fwd_nak_i), .stack_pos_i(4'h3), .stack_size_i(4'h5),
        .link_clk_i(link_clk_i), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i), .nv_word_i(14'h0000),
        .nv_word_valid_i(1'b0), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .adc_start_o(adc_start_o), .adc_sel_o(adc_sel_o),
        .wire_test_o(wire_test_o), .scan_cont_o(scan_cont_o), .balance_enable_flag_o(bal_o),
        .register_checksum_fault_o(fault_o), .sleep_o(sleep_o), .wake_clk_o(wake_clk_o), .own_addr_o(own_addr_o),
        .stack_size_o(stack_size_o), .nv_reload_o(nv_reload_o));
    mcd_adc_model u_adc (.clk_i(clk_i), .start_i(adc_start_o), .sel_i(adc_sel_o), .done_o(adc_done_i),
        .data_o(adc_data_i));
    // ==================== shared tasks ====================
    always @(posedge clk_i)
    begin
        n_done += int'(adc_done_i === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one request pulse, answer sampled in its single cycle
    task automatic xfer(input logic wr, input logic [3:0] stk, input logic [2:0] pg, input logic [5:0] ad,
                        input logic ev, input logic [5:0] ec);
        @(posedge clk_i) #1;
        req_i = {wr, stk, pg, ad, 14'h0000};
        req_valid_i = 1'b1;
        @(posedge clk_i) #1;
        req_valid_i = 1'b0;
        got = rsp_o;
        chk("answer", {ev, ec}, {rsp_valid_o, ev ? rsp_o.code : ec});
    endtask
    task automatic cmd(input logic [5:0] ad, input logic [3:0] stk);
        xfer(1'b0, stk, PAGE_CMD, ad, 1'b1, CMD_ACK);
    endtask
    task automatic cfg_csum(input logic [DATA_W-1:0] v, input logic exp);
        @(posedge clk_i) #1;
        {cfg_wr_i, cfg_addr_i, cfg_wdata_i} = {1'b1, ADDR_CFG_FIRST, v};
        @(posedge clk_i) #1;
        cfg_wr_i = 1'b0;
        cmd(CMD_CSUM_CHECK, 4'h0);
        repeat (64) if (fault_o !== exp) @(posedge clk_i);
        chk("checksum fault", 20'(exp), 20'(fault_o));
    endtask
    // ==================== scenarios ====================
    task automatic scan(input logic [5:0] c, input int k);
        int t;
        cmd(c, 4'h0);
        t = n_done + k;
        repeat (2000) if (n_done < t) @(posedge clk_i);
        chk("conversions", 20'(t), 20'(n_done));
    endtask
    task automatic t_scan();
        scan(CMD_SCAN_VOLT, 13);
        for (int i = 0; i < 13; i++)
        begin
            xfer(1'b0, 4'h0, PAGE_RESULT, 6'(i), 1'b1, 6'h00);
            chk("result", {6'h20, (i == 0) ? 8'h10 : 8'(i - 1)}, got.rdata);
        end
        scan(CMD_SCAN_MIXED, 14);
        scan(CMD_SCAN_ALL, 31);
    endtask
    task automatic t_flags();
        cmd(CMD_BAL_EN, 4'h0);
        cmd(CMD_BAL_INH, 4'hF);
        chk("balance", 20'h0, bal_o);
        cmd(CMD_BAL_EN, 4'hF);
        cmd(CMD_ACK, 4'h0);
        chk("balance", 20'h1, bal_o);
        xfer(1'b0, 4'h0, PAGE_CMD, 6'h0D, 1'b1, RSP_NAK);
        xfer(1'b1, 4'h0, PAGE_CMD, CMD_ACK, 1'b1, RSP_NAK);
        cmd(CMD_SCAN_CONT, 4'h0);
        chk("scan", 20'h1, scan_cont_o);
        cmd(CMD_SCAN_INH, 4'h0);
        chk("scan", 20'h0, scan_cont_o);
        @(posedge clk_i) #1;
        fwd_nak_i = 1'b1;
        @(posedge clk_i) #1;
        fwd_nak_i = 1'b0;
        chk("comms failure", {1'b1, RSP_COMMS_FAIL}, {rsp_valid_o, rsp_o.code});
        xfer(1'b0, 4'h0, PAGE_NV, ADDR_NV_SIG, 1'b1, 6'h00);
        chk("factory signature", 20'(SIG), got.rdata);
        cmd(CMD_CSUM_CALC, 4'h0);
        cfg_csum(14'h0000, 1'b0);
        cfg_csum(14'h0222, 1'b1);
    endtask
    task automatic t_power();
        int n;
        logic last;
        cmd(CMD_RESET, 4'h0);
        chk("balance", 20'h0, {bal_o, scan_cont_o});
        xfer(1'b0, 4'h0, PAGE_RESULT, 6'h05, 1'b1, 6'h00);
        chk("cleared result", 20'h0, got.rdata);
        cmd(CMD_SLEEP, 4'h0);
        xfer(1'b0, 4'h0, PAGE_CMD, CMD_ACK, 1'b0, 6'h00);
        repeat (2) #80 link_clk_i = ~link_clk_i;
        repeat (50) if (sleep_o !== 1'b0) @(posedge clk_i);
        chk("awake", 20'h0, sleep_o);
        cmd(CMD_WAKE, 4'h0);
        {n, last} = {32'h0, wake_clk_o};
        repeat (600)
        begin
            @(posedge clk_i) #1;
            n += int'(wake_clk_o !== last);
            last = wake_clk_o;
        end
        chk("wake toggles", 20'h10, 20'(n));
        cmd(CMD_IDENTIFY, 4'h0);
        chk("stack place", 20'h35, {own_addr_o, stack_size_o});
        cmd(CMD_ACK, 4'h3);
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        t_scan();
        t_flags();
        t_power();
        end_of_test();
    end
endmodule
`default_nettype wire
